// ===== common/dpd_pkg.sv
package dpd_pkg;

	// System clock period and the timing figures of the potentiometer.
	localparam int CLK_PERIOD_NS = 10;
	localparam int NV_WRITE_TIME_NS = 10_000_000;
	localparam int NV_WRITE_CYCLES = (NV_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WIPER_RESPONSE_DELAY_NS = 1000;
	localparam int WIPER_RESPONSE_CYCLES = (WIPER_RESPONSE_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
		WIPER_RESPONSE_DELAY_NS / CLK_PERIOD_NS;

	// Tap range of one wiper and the stored setting reset value.
	localparam int TAP_BITS = 6;
	localparam logic [5:0] TAP_MAX = 6'h3f;
	localparam logic [5:0] TAP_MIN = 6'h00;
	localparam logic [5:0] STORED_RESET = 6'h00;

	// Identification byte fields.
	localparam int ID_TYPE_MSB = 7;
	localparam int ID_TYPE_LSB = 4;
	localparam int ID_ADDR_MSB = 1;
	localparam int ID_ADDR_LSB = 0;

	// Instruction byte fields.
	localparam int OPC_MSB = 7;
	localparam int OPC_LSB = 4;
	localparam int IDX_MSB = 3;
	localparam int IDX_LSB = 2;
	localparam int POT_POS = 0;

	// Instruction opcodes.
	localparam logic [3:0] OP_RD_WIPER = 4'h9;
	localparam logic [3:0] OP_WR_WIPER = 4'ha;
	localparam logic [3:0] OP_RD_STORED = 4'hb;
	localparam logic [3:0] OP_WR_STORED = 4'hc;
	localparam logic [3:0] OP_XFR_S2W = 4'hd;
	localparam logic [3:0] OP_XFR_W2S = 4'he;
	localparam logic [3:0] OP_GXFR_S2W = 4'h1;
	localparam logic [3:0] OP_GXFR_W2S = 4'h8;
	localparam logic [3:0] OP_INCDEC = 4'h2;
	localparam logic [3:0] OP_STATUS = 4'h5;
	localparam logic [1:0] IDX_ZERO = 2'h0;

	// Byte phase of a serial frame.
	typedef enum logic [1:0] {PH_ID, PH_INSTR, PH_DATA, PH_DONE} dpd_phase_e;

endpackage : dpd_pkg

// ===== verif/dpd_host_model.sv
`timescale 1ns/1ps
module dpd_host_model (
	// Serial link driven by the host.
	output logic sck,
	output logic cs_n,
	output logic si,
	// Answer lines from the device.
	input wire logic so_o,
	input wire logic so_oe
);
	// The link idles deselected with its clock parked low.
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// Sends n bits of w, first bit first, and gathers the answer byte and its enable count.
	task automatic xfer(input logic [31:0] w, input int n, output logic [7:0] rd,
		output logic [7:0] oe_cnt);
		int i;
		rd = 8'h00;
		oe_cnt = 8'h00;
		#13;
		cs_n = 1'b0;
		#32;
		for (i = 0; i < n; i++)
		begin
			si = w[31 - i];
			#32;
			if (i >= 16)
			begin
				rd = {rd[6:0], so_o};
				oe_cnt = oe_cnt + {7'h00, so_oe};
			end
			sck = 1'b1;
			#32;
			sck = 1'b0;
		end
		#32;
		cs_n = 1'b1;
		// A released data line shows the opposite level, so stale data is never trusted.
		si = ~si;
		#64;
	endtask : xfer
endmodule : dpd_host_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import dpd_pkg::*;

	// Shortened counts and the strap setting of this bench.
	localparam int NV_SIM = 400;
	localparam logic [3:0] TYPE_CODE = 4'h6; // Arbitrary type code value.
	localparam logic [1:0] STRAP = 2'h2;
	localparam logic [7:0] ID_OK = {TYPE_CODE, 2'h0, STRAP};

	typedef struct {logic [31:0] w; int n; logic rdc; logic [7:0] rd;
		logic [5:0] w0; logic [5:0] w1; logic wip; logic drain;} dpd_row_s;

	// Bench signals.
	logic clk, rst_n, sck, cs_n, si, so_o, so_oe, wip;
	logic [1:0] strap;
	logic [5:0] w0, w1;
	logic [7:0] rd, oe_cnt;
	int err_count, tests_run, i, k;
	dpd_row_s rows [0:21];

	// Device under test and the host on its link.
	dpd_serial_decoder #(.DEVICE_TYPE(TYPE_CODE), .NV_CYCLES(NV_SIM), .WIPER_DELAY(3)) dut (
		.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o),
		.so_oe(so_oe), .address_strap_inputs(strap), .wiper0_pos(w0), .wiper1_pos(w1),
		.write_in_progress(wip));
	dpd_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe));

	// Frame builders: identification, opcode, pointer nibble, data byte.
	function automatic logic [31:0] mki(input logic [7:0] id, input logic [3:0] op,
		input logic [3:0] ptr, input logic [7:0] d);
		return {id, op, ptr, d, 8'h00};
	endfunction : mki
	function automatic logic [31:0] mk(input logic [3:0] op, input logic [3:0] ptr,
		input logic [7:0] d);
		return mki(ID_OK, op, ptr, d);
	endfunction : mk

	// Compare tasks, one for each kind of result.
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t: byte %h expected %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic chk_tap(input logic [5:0] got, input logic [5:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t: tap %h expected %h", $time, got, exp);
		end
	endtask : chk_tap
	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : chk_bit

	// Prints the counts and the verdict, then stops.
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	// Waits a bounded time for the write to end and returns the cycles spent.
	task automatic wait_idle(output int c);
		for (c = 0; c < 1000 && wip !== 1'b0; c++)
		begin
			@(posedge clk);
			#1;
		end
		if (wip !== 1'b0)
		begin
			err_count++;
			$display("ERROR %0t: write never ended", $time);
			end_sim();
		end
	endtask : wait_idle

	// System clock.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Main sequence.
	initial
	begin
		rst_n = 1'b0;
		strap = STRAP;
		err_count = 0;
		tests_run = 0;
		rows[0] = '{mk(OP_WR_WIPER, 4'h0, 8'h15), 24, 1'b0, 8'h00, 6'h15, 6'h00, 1'b0, 1'b0};
		rows[1] = '{mk(OP_RD_WIPER, 4'h0, 8'h00), 24, 1'b1, 8'h15, 6'h15, 6'h00, 1'b0, 1'b0};
		rows[2] = '{mk(OP_WR_STORED, 4'h9, 8'h2a), 24, 1'b0, 8'h00, 6'h15, 6'h00, 1'b1, 1'b0};
		rows[3] = '{mk(OP_STATUS, 4'h1, 8'h00), 24, 1'b1, 8'h01, 6'h15, 6'h00, 1'b1, 1'b1};
		rows[4] = '{mk(OP_STATUS, 4'h1, 8'h00), 24, 1'b1, 8'h00, 6'h15, 6'h00, 1'b0, 1'b0};
		rows[5] = '{mk(OP_RD_STORED, 4'h9, 8'h00), 24, 1'b1, 8'h2a, 6'h15, 6'h00, 1'b0, 1'b0};
		rows[6] = '{mk(OP_XFR_S2W, 4'h9, 8'h00), 16, 1'b0, 8'h00, 6'h15, 6'h2a, 1'b0, 1'b0};
		rows[7] = '{mk(OP_GXFR_W2S, 4'h4, 8'h00), 16, 1'b0, 8'h00, 6'h15, 6'h2a, 1'b1, 1'b1};
		rows[8] = '{mk(OP_WR_WIPER, 4'h1, 8'h3e), 24, 1'b0, 8'h00, 6'h15, 6'h3e, 1'b0, 1'b0};
		rows[9] = '{mk(OP_WR_WIPER, 4'h0, 8'h07), 24, 1'b0, 8'h00, 6'h07, 6'h3e, 1'b0, 1'b0};
		rows[10] = '{mk(OP_GXFR_S2W, 4'h4, 8'h00), 16, 1'b0, 8'h00, 6'h15, 6'h2a, 1'b0, 1'b0};
		rows[11] = '{mk(OP_XFR_W2S, 4'hc, 8'h00), 16, 1'b0, 8'h00, 6'h15, 6'h2a, 1'b1, 1'b1};
		rows[12] = '{mk(OP_RD_STORED, 4'hc, 8'h00), 24, 1'b1, 8'h15, 6'h15, 6'h2a, 1'b0, 1'b0};
		rows[13] = '{mki({~TYPE_CODE, 2'h0, STRAP}, OP_WR_WIPER, 4'h0, 8'h01), 24, 1'b0, 8'h00,
			6'h15, 6'h2a, 1'b0, 1'b0};
		rows[14] = '{mki({TYPE_CODE, 2'h0, ~STRAP}, OP_WR_WIPER, 4'h0, 8'h01), 24, 1'b0, 8'h00,
			6'h15, 6'h2a, 1'b0, 1'b0};
		rows[15] = '{mk(OP_WR_STORED, 4'h0, 8'h3f), 20, 1'b0, 8'h00, 6'h15, 6'h2a, 1'b0, 1'b0};
		rows[16] = '{mk(OP_RD_STORED, 4'h0, 8'h00), 24, 1'b1, {2'h0, STORED_RESET}, 6'h15, 6'h2a,
			1'b0, 1'b0};
		rows[17] = '{mk(OP_WR_WIPER, 4'h0, 8'h3d), 24, 1'b0, 8'h00, 6'h3d, 6'h2a, 1'b0, 1'b0};
		rows[18] = '{mk(OP_INCDEC, 4'h0, 8'he0), 19, 1'b0, 8'h00, 6'h3f, 6'h2a, 1'b0, 1'b0};
		rows[19] = '{mk(OP_WR_WIPER, 4'h1, 8'h01), 24, 1'b0, 8'h00, 6'h3f, 6'h01, 1'b0, 1'b0};
		rows[20] = '{mk(OP_INCDEC, 4'h1, 8'h10), 20, 1'b0, 8'h00, 6'h3f, 6'h01, 1'b0, 1'b0};
		rows[21] = '{mk(OP_RD_WIPER, 4'h1, 8'h00), 24, 1'b1, 8'h01, 6'h3f, 6'h01, 1'b0, 1'b0};
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		chk_tap(w0, STORED_RESET);
		chk_bit(wip, 1'b0);
		chk_bit(so_oe, 1'b0);
		$display("Power-up test done");
		repeat (2) @(posedge clk);
		// Ordinary cases from the table.
		for (i = 0; i < 22; i++)
		begin
			host.xfer(rows[i].w, rows[i].n, rd, oe_cnt);
			repeat (15) @(posedge clk);
			#1;
			if (rows[i].rdc)
				chk_byte(rd, rows[i].rd);
			chk_byte(oe_cnt, rows[i].rdc ? 8'h08 : 8'h00);
			chk_tap(w0, rows[i].w0);
			chk_tap(w1, rows[i].w1);
			chk_bit(wip, rows[i].wip);
			chk_bit(so_oe, 1'b0);
			if (rows[i].drain)
				wait_idle(k);
			$display("Row %0d done", i);
		end
		// A full stored write keeps the flag up for the write time and stores six bits.
		host.xfer(mk(OP_WR_STORED, 4'h0, 8'hff), 24, rd, oe_cnt);
		chk_bit(wip, 1'b1);
		wait_idle(k);
		chk_bit(k >= NV_SIM - 12 && k <= NV_SIM + 2, 1'b1);
		host.xfer(mk(OP_RD_STORED, 4'h0, 8'h00), 24, rd, oe_cnt);
		chk_byte(rd, 8'h3f);
		$display("Write time test done");
		// Reset in mid-run returns the wipers to the stored reset value.
		@(posedge clk);
		#1 rst_n = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk_tap(w0, STORED_RESET);
		chk_tap(w1, STORED_RESET);
		rst_n = 1'b1;
		repeat (2) @(posedge clk);
		host.xfer(mk(OP_RD_WIPER, 4'h1, 8'h00), 24, rd, oe_cnt);
		chk_byte(rd, {2'h0, STORED_RESET});
		$display("Reset test done");
		end_sim();
	end
endmodule : tb_top

// ===== verilog/dpd_serial_decoder.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: First byte after chip select falls is always the identification byte.
// RULE2: Upper identification nibble must equal the device type code to proceed.
// RULE3: Lowest two identification bits must match both address straps.
// RULE4: Host sends the two middle identification bits as zero.
// RULE5: Instruction byte: opcode, register index, zero bit, pot select bit.
// RULE6: Four transfer instructions end after the instruction byte.
// RULE7: Stored-to-wiper transfer loads the wiper; output follows after response delay.
// RULE8: Wiper-to-stored transfer starts a nonvolatile write of full write time.
// RULE9: Global transfers move both pots with the same register index.
// RULE10: Wiper and stored reads/writes and status read use a three-byte frame.
// RULE11: Opcode 1001 reads, 1010 writes the wiper, register bits 00.
// RULE12: Opcode 1011 reads, 1100 writes the selected stored setting.
// RULE13: Opcodes 1101, 1110, 0001, 1000 are the four transfers.
// RULE14: Opcode 0101, index 00, pot 1 returns the write-in-progress flag.
// RULE15: Wiper read sends two zeros then six position bits, MSB first.
// RULE16: Opcode 0010 enters step mode until chip select rises.
// RULE17: Step with serial input high moves wiper toward high terminal.
// RULE18: Step with serial input low moves wiper toward low terminal.
// RULE19: Host holds serial input steady through the high clock phase.
// RULE20: Serial input sampled on rising link clock, chip select low throughout.
// RULE21: Nonvolatile write starts at chip select rise; busy flag set meanwhile.
// RULE22: Stored settings are six bits; a write lasts the nonvolatile time.
// RULE23: Status read sends seven zeros then the busy flag.
// RULE24: Stepping saturates at tap 0 and tap 63.
// RULE25: Mismatched identification ignores the frame; framing restarts each select.
module dpd_serial_decoder
	import dpd_pkg::*;
#(
	parameter logic [3:0] DEVICE_TYPE = 4'ha, // Arbitrary type code value.
	parameter int NV_CYCLES = dpd_pkg::NV_WRITE_CYCLES,
	parameter int WIPER_DELAY = dpd_pkg::WIPER_RESPONSE_CYCLES
) (
	// System clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Serial link.
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so_o,
	output logic so_oe,
	// Address straps.
	input wire logic [1:0] address_strap_inputs,
	// Wiper positions and status.
	output logic [5:0] wiper0_pos,
	output logic [5:0] wiper1_pos,
	output logic write_in_progress
);

	localparam int NV_W = $clog2(NV_CYCLES + 1);

	// Link domain state; framing state is cleared whenever chip select is high.
	logic link_rst_n;
	dpd_phase_e phase_reg;
	dpd_phase_e phase_next;
	logic [2:0] bit_cnt_reg;
	logic [6:0] shift_reg;
	logic ignore_reg;
	logic incdec_reg;
	logic [7:0] tx_reg;
	logic so_oe_reg;
	// Link domain holding registers, kept across frames for the crossing.
	logic [1:0] strap_s1_reg;
	logic [1:0] strap_s2_reg;
	logic [5:0] req_info_reg;
	logic [7:0] instr_reg;
	logic [7:0] data_byte_reg;
	logic step_dir_reg;
	logic req_tog_reg;
	logic cmd_tog_reg;
	logic data_tog_reg;
	logic step_tog_reg;
	logic ack_s1_reg;
	logic ack_s2_reg;
	// System domain state.
	logic [2:0] cs_sync_reg;
	logic [3:0] tog_s1_reg;
	logic [3:0] tog_s2_reg;
	logic [3:0] tog_s3_reg;
	logic [5:0] wiper_reg [2];
	logic [5:0] wiper_next [2];
	logic [5:0] stored_reg [8];
	logic [5:0] stored_next [8];
	logic pend_valid_reg;
	logic pend_global_reg;
	logic pend_data_reg;
	logic incdec_on_reg;
	logic [NV_W-1:0] nv_cnt_reg;
	logic wip_reg;
	logic [7:0] ans0_reg;
	logic [7:0] ans1_reg;
	logic ans_tog_reg;

	// Link side decode of the byte being received.
	wire [7:0] rx_byte = {shift_reg, si};
	wire [3:0] rx_op = rx_byte[OPC_MSB:OPC_LSB];
	wire byte_done = bit_cnt_reg == 3'h7 && !ignore_reg && !incdec_reg;
	wire id_done = byte_done && phase_reg == PH_ID;
	wire instr_done = byte_done && phase_reg == PH_INSTR;
	wire data_done = byte_done && phase_reg == PH_DATA;
	// RULE2 RULE3: type and strap compare.
	wire id_match = rx_byte[ID_TYPE_MSB:ID_TYPE_LSB] == DEVICE_TYPE &&
		rx_byte[ID_ADDR_MSB:ID_ADDR_LSB] == strap_s2_reg;
	wire req_now = phase_reg == PH_INSTR && bit_cnt_reg == 3'h5 && !ignore_reg;
	wire three_byte = rx_op == OP_RD_WIPER || rx_op == OP_WR_WIPER || rx_op == OP_RD_STORED ||
		rx_op == OP_WR_STORED || rx_op == OP_STATUS;
	wire [3:0] fr_op = instr_reg[OPC_MSB:OPC_LSB];
	wire rd_instr = fr_op == OP_RD_WIPER || fr_op == OP_RD_STORED || fr_op == OP_STATUS;
	wire tx_load = phase_reg == PH_DATA && bit_cnt_reg == 3'h0 && rd_instr &&
		ack_s2_reg == req_tog_reg;

	assign link_rst_n = rst_n & ~cs_n;
	assign so_o = tx_reg[7];
	assign so_oe = so_oe_reg;

	// RULE1: byte phase sequence.
	always_comb
	begin
		case (phase_reg)
			PH_ID: phase_next = id_match ? PH_INSTR : PH_DONE;
			// RULE6: two-byte transfers end here.
			PH_INSTR: phase_next = three_byte ? PH_DATA : PH_DONE;
			PH_DATA: phase_next = PH_DONE;
			default: phase_next = PH_DONE;
		endcase
	end

	// RULE20: bits shift in on the rising link clock.
	always_ff @(posedge sck or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			phase_reg <= PH_ID;
			bit_cnt_reg <= 3'h0;
			shift_reg <= 7'h00;
			ignore_reg <= 1'b0;
			incdec_reg <= 1'b0;
		end
		else
		begin
			shift_reg <= rx_byte[6:0];
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			// RULE25: mismatch silences the frame.
			if (id_done && !id_match)
				ignore_reg <= 1'b1;
			// RULE16: open-ended step mode.
			if (instr_done && rx_op == OP_INCDEC)
				incdec_reg <= 1'b1;
			if (byte_done)
				phase_reg <= phase_next;
		end
	end

	// Holding registers and toggles; a frame reset must not fake a toggle edge.
	always_ff @(posedge sck or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_s1_reg <= 2'h0;
			strap_s2_reg <= 2'h0;
			req_info_reg <= 6'h00;
			instr_reg <= 8'h00;
			data_byte_reg <= 8'h00;
			step_dir_reg <= 1'b0;
			req_tog_reg <= 1'b0;
			cmd_tog_reg <= 1'b0;
			data_tog_reg <= 1'b0;
			step_tog_reg <= 1'b0;
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
		end
		else
		begin
			strap_s1_reg <= address_strap_inputs;
			strap_s2_reg <= strap_s1_reg;
			ack_s1_reg <= ans_tog_reg;
			ack_s2_reg <= ack_s1_reg;
			if (req_now)
			begin
				req_info_reg <= rx_byte[5:0];
				req_tog_reg <= ~req_tog_reg;
			end
			if (instr_done)
			begin
				instr_reg <= rx_byte;
				cmd_tog_reg <= ~cmd_tog_reg;
			end
			if (data_done)
			begin
				data_byte_reg <= rx_byte;
				data_tog_reg <= ~data_tog_reg;
			end
			// RULE19: direction taken at the rising edge of the step pulse.
			if (incdec_reg)
			begin
				step_dir_reg <= si;
				step_tog_reg <= ~step_tog_reg;
			end
		end
	end

	// RULE15: read data leaves MSB first, changing on the falling edge.
	always_ff @(negedge sck or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			tx_reg <= 8'h00;
			so_oe_reg <= 1'b0;
		end
		else if (tx_load)
		begin
			tx_reg <= instr_reg[POT_POS] ? ans1_reg : ans0_reg;
			so_oe_reg <= 1'b1;
		end
		else
		begin
			tx_reg <= {tx_reg[6:0], 1'b0};
			so_oe_reg <= so_oe_reg && phase_reg == PH_DATA;
		end
	end

	// Synchronisers for chip select and the four event toggles.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_sync_reg <= 3'h7;
			tog_s1_reg <= 4'h0;
			tog_s2_reg <= 4'h0;
			tog_s3_reg <= 4'h0;
		end
		else
		begin
			cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
			tog_s1_reg <= {req_tog_reg, cmd_tog_reg, data_tog_reg, step_tog_reg};
			tog_s2_reg <= tog_s1_reg;
			tog_s3_reg <= tog_s2_reg;
		end
	end

	// System side events and decode of the held instruction.
	wire [3:0] ev = tog_s2_reg ^ tog_s3_reg;
	wire ev_req = ev[3];
	wire ev_cmd = ev[2];
	wire ev_data = ev[1];
	wire ev_step = ev[0];
	wire frame_end = cs_sync_reg[1] && !cs_sync_reg[2];
	wire frame_start = !cs_sync_reg[1] && cs_sync_reg[2];
	// RULE5: instruction fields.
	wire [1:0] idx = instr_reg[IDX_MSB:IDX_LSB];
	wire pot = instr_reg[POT_POS];
	wire op_s2w = fr_op == OP_XFR_S2W;
	wire op_gs2w = fr_op == OP_GXFR_S2W;
	wire op_w2s = fr_op == OP_XFR_W2S;
	wire op_gw2s = fr_op == OP_GXFR_W2S;
	// RULE11: wiper access only with index 00.
	wire op_wr_wiper = fr_op == OP_WR_WIPER && idx == IDX_ZERO;
	wire op_wr_stored = fr_op == OP_WR_STORED;
	wire [5:0] xfr_src = stored_reg[{pot, idx}];
	wire [5:0] cur_wiper = wiper_reg[pot];
	// RULE24: steps saturate at the end taps.
	wire [5:0] step_up = cur_wiper == TAP_MAX ? TAP_MAX : cur_wiper + 6'h01;
	wire [5:0] step_dn = cur_wiper == TAP_MIN ? TAP_MIN : cur_wiper - 6'h01;
	wire commit = frame_end && pend_valid_reg && !wip_reg;
	wire [3:0] rq_op = req_info_reg[5:2];
	wire [1:0] rq_idx = req_info_reg[1:0];

	// RULE13: wiper loads from transfers, writes and steps.
	always_comb
	begin
		wiper_next = wiper_reg;
		// RULE7: stored setting into the wiper register.
		if (ev_cmd && op_s2w)
			wiper_next[pot] = xfr_src;
		// RULE9: both pots from the same index.
		if (ev_cmd && op_gs2w)
		begin
			wiper_next[0] = stored_reg[{1'b0, idx}];
			wiper_next[1] = stored_reg[{1'b1, idx}];
		end
		if (ev_data && op_wr_wiper)
			wiper_next[pot] = data_byte_reg[5:0];
		// RULE17: high steps up; RULE18: low steps down.
		if (ev_step && incdec_on_reg)
			wiper_next[pot] = step_dir_reg ? step_up : step_dn;
	end

	// RULE22: six-bit stored settings change only on commit.
	always_comb
	begin
		stored_next = stored_reg;
		if (commit && pend_global_reg)
		begin
			stored_next[{1'b0, idx}] = wiper_reg[0];
			stored_next[{1'b1, idx}] = wiper_reg[1];
		end
		else if (commit)
			stored_next[{pot, idx}] = pend_data_reg ? data_byte_reg[5:0] : cur_wiper;
	end

	// Wiper and stored registers; power-up wiper equals the stored reset value.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wiper_reg <= '{default: STORED_RESET};
			stored_reg <= '{default: STORED_RESET};
		end
		else
		begin
			wiper_reg <= wiper_next;
			stored_reg <= stored_next;
		end
	end

	// RULE8: nonvolatile writes wait for chip select to rise.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pend_valid_reg <= 1'b0;
			pend_global_reg <= 1'b0;
			pend_data_reg <= 1'b0;
			incdec_on_reg <= 1'b0;
		end
		else
		begin
			if (frame_start || frame_end)
			begin
				pend_valid_reg <= 1'b0;
				incdec_on_reg <= 1'b0;
			end
			if (ev_cmd && (op_w2s || op_gw2s))
			begin
				pend_valid_reg <= 1'b1;
				pend_global_reg <= op_gw2s;
				pend_data_reg <= 1'b0;
			end
			// RULE12: stored write waits for its data byte.
			if (ev_data && op_wr_stored)
			begin
				pend_valid_reg <= 1'b1;
				pend_global_reg <= 1'b0;
				pend_data_reg <= 1'b1;
			end
			if (ev_cmd && fr_op == OP_INCDEC)
				incdec_on_reg <= 1'b1;
		end
	end

	// RULE21: busy flag runs for the nonvolatile write time.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nv_cnt_reg <= '0;
			wip_reg <= 1'b0;
		end
		else if (commit)
		begin
			nv_cnt_reg <= NV_W'(NV_CYCLES);
			wip_reg <= 1'b1;
		end
		else if (nv_cnt_reg != '0)
		begin
			nv_cnt_reg <= nv_cnt_reg - NV_W'(1);
			wip_reg <= nv_cnt_reg != NV_W'(1);
		end
	end

	// RULE14: read answers for both pots, prepared before the pot bit arrives.
	wire [7:0] ans_w0 = rq_op == OP_RD_WIPER && rq_idx == IDX_ZERO ? {2'h0, wiper_reg[0]} :
		rq_op == OP_RD_STORED ? {2'h0, stored_reg[{1'b0, rq_idx}]} : 8'h00;
	// RULE23: status answer is the busy flag in bit zero.
	wire [7:0] ans_w1 = rq_op == OP_RD_WIPER && rq_idx == IDX_ZERO ? {2'h0, wiper_reg[1]} :
		rq_op == OP_RD_STORED ? {2'h0, stored_reg[{1'b1, rq_idx}]} :
		rq_op == OP_STATUS && rq_idx == IDX_ZERO ? {7'h00, wip_reg} : 8'h00;

	// RULE10: answer word handed to the link with a toggle.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ans0_reg <= 8'h00;
			ans1_reg <= 8'h00;
			ans_tog_reg <= 1'b0;
		end
		else if (ev_req)
		begin
			ans0_reg <= ans_w0;
			ans1_reg <= ans_w1;
			ans_tog_reg <= ~ans_tog_reg;
		end
	end

	// Applied wiper outputs lag the wiper registers.
	dpd_wiper_follow #(.DELAY_CYCLES(WIPER_DELAY), .RESET_POS(STORED_RESET)) u_follow0 (
		.clk(clk),
		.rst_n(rst_n),
		.target_pos(wiper_reg[0]),
		.wiper_pos(wiper0_pos)
	);
	dpd_wiper_follow #(.DELAY_CYCLES(WIPER_DELAY), .RESET_POS(STORED_RESET)) u_follow1 (
		.clk(clk),
		.rst_n(rst_n),
		.target_pos(wiper_reg[1]),
		.wiper_pos(wiper1_pos)
	);
	assign write_in_progress = wip_reg;

	// Checks on the link side.
	id_reject_a: assert property (@(posedge sck) disable iff (!link_rst_n) // RULE3
		id_done && !id_match |=> ignore_reg && phase_reg == PH_DONE)
		else $error("Identification mismatch did not silence the frame.");
	type_check_a: assert property (@(posedge sck) disable iff (!link_rst_n) // RULE2
		id_done && rx_byte[7:4] != DEVICE_TYPE |=> phase_reg != PH_INSTR)
		else $error("Wrong type code reached the instruction byte.");
	quiet_frame_a: assert property (@(posedge sck) disable iff (!link_rst_n) // RULE25
		ignore_reg |=> $stable(cmd_tog_reg) && $stable(data_tog_reg) && $stable(req_tog_reg))
		else $error("Ignored frame produced an event.");

	// Checks on the system side.
	sequence commit_s;
		frame_end && pend_valid_reg && !wip_reg;
	endsequence
	wip_set_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
		commit_s |=> wip_reg [*2])
		else $error("Busy flag not raised by a committed write.");
	wip_len_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE22
		$fell(wip_reg) |-> nv_cnt_reg == '0 && $past(nv_cnt_reg) == NV_W'(1))
		else $error("Busy flag dropped before the write time.");
	s2w_load_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
		ev_cmd && op_s2w |=> wiper_reg[$past(pot)] == $past(xfr_src))
		else $error("Stored-to-wiper transfer lost.");
	global_load_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
		ev_cmd && op_gs2w |=> wiper_reg[0] == $past(stored_reg[{1'b0, idx}]) &&
		wiper_reg[1] == $past(stored_reg[{1'b1, idx}]))
		else $error("Global transfer did not load both wipers.");
	step_up_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
		ev_step && incdec_on_reg && step_dir_reg && cur_wiper != TAP_MAX
		|=> wiper_reg[pot] == $past(cur_wiper) + 6'h01)
		else $error("Step up did not advance the wiper.");
	step_dn_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
		ev_step && incdec_on_reg && !step_dir_reg && cur_wiper != TAP_MIN
		|=> wiper_reg[pot] == $past(cur_wiper) - 6'h01)
		else $error("Step down did not move the wiper back.");
	end_tap_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE24
		ev_step && incdec_on_reg && step_dir_reg && cur_wiper == TAP_MAX |=> cur_wiper == TAP_MAX)
		else $error("Wiper wrapped past the top tap.");
	status_ans_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE23
		ev_req && rq_op == OP_STATUS && rq_idx == IDX_ZERO |=> ans1_reg == {7'h00, $past(wip_reg)})
		else $error("Status answer does not carry the busy flag.");
	wiper_ans_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
		ev_req && rq_op == OP_RD_WIPER && rq_idx == IDX_ZERO
		|=> ans0_reg == {2'h0, $past(wiper_reg[0])})
		else $error("Wiper read answer malformed.");

endmodule : dpd_serial_decoder

// ===== verilog/dpd_wiper_follow.sv
`timescale 1ns/1ps
module dpd_wiper_follow
	import dpd_pkg::*;
#(
	parameter int DELAY_CYCLES = dpd_pkg::WIPER_RESPONSE_CYCLES,
	parameter logic [5:0] RESET_POS = dpd_pkg::STORED_RESET
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Wanted and applied wiper position.
	input wire logic [5:0] target_pos,
	output logic [5:0] wiper_pos
);

	localparam int CNT_W = $clog2(DELAY_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DELAY_CYCLES - 1);

	logic [CNT_W-1:0] cnt_reg;
	logic differs;

	// The count keeps running if the target moves again, so a burst lands at once.
	assign differs = target_pos != wiper_pos;

	// RULE7: delayed wiper response.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg <= '0;
			wiper_pos <= RESET_POS;
		end
		else if (differs && cnt_reg == CNT_LAST)
		begin
			cnt_reg <= '0;
			wiper_pos <= target_pos;
		end
		else
		begin
			cnt_reg <= differs ? cnt_reg + CNT_W'(1) : '0;
		end
	end

	follow_delay_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
		$changed(wiper_pos) |-> $past(cnt_reg) == CNT_LAST && wiper_pos == $past(target_pos))
		else $error("Wiper moved before the response delay ran out.");

endmodule : dpd_wiper_follow
